// ### include/lbarb_pkg.sv
// Package: constants, states and carriers of the local bus arbiter
package lbarb_pkg;

  // ----------------------------------------------------------
  // Timing
  // ----------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;  // System clock period
  localparam int TIMING_UNIT_NS = 20; // One timing unit
  // Least time: round up to whole cycles, at least one
  localparam int UNIT_CYCLES_RAW =
    (TIMING_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int UNIT_CYCLES =
    (UNIT_CYCLES_RAW < 1) ? 1 : UNIT_CYCLES_RAW;
  localparam int TMR_W = 4;           // Timer counter width
  localparam logic [1:0] UNITS_ONE = 2'h1; // Spacing of one
  localparam logic [1:0] UNITS_TWO = 2'h2; // Init pulse length

  // ----------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------
  localparam logic PIN_IDLE_LEVEL = 1'h1;  // Active-low idle
  localparam logic ROLE_AT_RESET = 1'h0;   // Slave role

  // ----------------------------------------------------------
  // Types
  // ----------------------------------------------------------
  // Arbitration sequence states of both roles
  typedef enum logic [3:0] {
    M_NORMAL, M_RELEASE, M_ACK, M_HOLD, M_EXIT,
    S_HOLD, S_PULSE, S_TAKE, S_OWN, S_BACKOFF, S_RELEASE,
    S_WAIT
  } lbarb_state_e_t;

  // Pin-facing outputs, grouped
  typedef struct packed {
    logic holdAckOut;   // Hold acknowledge value, master only
    logic holdAckOe;    // Hold acknowledge driven
    logic busRequestN;  // Bus request, active low
    logic addrDataOe;   // Address and data buses driven
    logic strobeOe;     // Read, write, byte-high driven
    logic aleOe;        // Address latch enable driven
  } lbarb_pin_out_t;

  // Synchroniser and edge detector state
  typedef struct packed {
    logic stage1;
    logic stage2;
    logic stage3;
  } lbarb_sync_t;

  // Timing unit counter state
  typedef struct packed {
    logic             running;
    logic [TMR_W-1:0] count;
  } lbarb_tmr_t;

endpackage

// ### verilog/lbarb_edge_sync.sv
// Two-stage input synchroniser with edge detection
`timescale 1ns/100ps
`default_nettype none
module lbarb_edge_sync
  import lbarb_pkg::*;
#(
  parameter logic INIT = 1'h1       // Level held during reset
)
(
  input  wire logic clk_sys,
  input  wire logic reset,
  input  wire logic clkEn,
  input  wire logic pinIn,
  output logic      level,
  output logic      rise,
  output logic      fall
);

  lbarb_sync_t s_r;   // Registered state
  lbarb_sync_t s_nxt; // Next state

  // ----------------------------------------------------------
  // Shift chain
  // ----------------------------------------------------------
  // First stage only feeds the second; edges use later stages
  always_comb
  begin
    s_nxt = s_r;
    if (clkEn)
    begin
      s_nxt.stage1 = pinIn;
      s_nxt.stage2 = s_r.stage1;
      s_nxt.stage3 = s_r.stage2;
    end
  end

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
      s_r <= {INIT, INIT, INIT};
    else
      s_r <= s_nxt;
  end

  assign level = s_r.stage2;
  assign rise  = s_r.stage2 & ~s_r.stage3;
  assign fall  = ~s_r.stage2 & s_r.stage3;

endmodule
`default_nettype wire

// ### verilog/lbarb_unit_timer.sv
// Counter of whole timing units
`timescale 1ns/100ps
`default_nettype none
module lbarb_unit_timer
  import lbarb_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       reset,
  input  wire logic       clkEn,
  input  wire logic       start,  // Restart with a new length
  input  wire logic [1:0] units,  // Length in timing units
  output logic            done    // Length elapsed, one cycle
);

  lbarb_tmr_t t_r;   // Registered state
  lbarb_tmr_t t_nxt; // Next state

  // ----------------------------------------------------------
  // Count down
  // ----------------------------------------------------------
  // Loaded one short so done marks the exact elapsed edge
  always_comb
  begin
    t_nxt = t_r;
    if (clkEn)
    begin
      if (start)
      begin
        t_nxt.running = 1'h1;
        t_nxt.count = TMR_W'(int'(units) * UNIT_CYCLES - 1);
      end
      else if (t_r.running && t_r.count == '0)
        t_nxt.running = 1'h0;
      else if (t_r.running)
        t_nxt.count = t_r.count - TMR_W'(1);
    end
  end

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
      t_r <= '0;
    else
      t_r <= t_nxt;
  end

  assign done = t_r.running && (t_r.count == '0);

endmodule
`default_nettype wire

// ### verilog/lbarb_arbiter.sv
// Local bus master/slave hold arbitration for one controller
`timescale 1ns/100ps
`default_nettype none
module lbarb_arbiter
  import lbarb_pkg::*;
(
  input  wire logic      clk_sys,
  input  wire logic      reset,
  input  wire logic      clkEn,
  // Configuration levels
  input  wire logic      arbitrationMasterSelect,
  input  wire logic      holdResponseEnable,
  input  wire logic      multiplexedMode,
  // Arbitration pins
  input  wire logic      holdRequestN,
  input  wire logic      holdAckNIn,
  // External bus controller side
  input  wire logic      extAccessReq,
  input  wire logic      busCycleActive,
  output lbarb_pin_out_t pinOut,
  output logic           busOwned,
  output logic           holdStatus
);

  // ----------------------------------------------------------
  // State
  // ----------------------------------------------------------
  typedef struct packed {
    lbarb_state_e_t st;        // Sequence state
    logic           role;      // 1 master, 0 slave
    logic           holdPend;  // Master: hold request seen
    logic           ackTimeOk; // Master: one unit after ack
    logic           didCycle;  // Slave: one cycle performed
    logic           hreSeen;   // Previous enable level
    lbarb_pin_out_t pins;      // Pin-facing outputs
    logic           owned;     // Controller may start cycles
    logic           hold;      // In hold
  } lbarb_arb_t;

  lbarb_arb_t s_r;   // Registered state
  lbarb_arb_t s_nxt; // Next state

  logic       reqLevel;  // Synchronised hold request
  logic       reqRise;   // Hold request rising edge
  logic       reqFall;   // Hold request falling edge
  logic       ackFall;   // Acknowledge input falling edge
  logic       tmrStart;  // Restart the unit timer
  logic [1:0] tmrUnits;  // Units to load
  logic       tmrDone;   // Timer elapsed

  // ----------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------
  // Hold request is sampled through two flops
  lbarb_edge_sync #(
    .INIT (PIN_IDLE_LEVEL)
  ) u_req_sync (
    .clk_sys (clk_sys),
    .reset   (reset),
    .clkEn   (clkEn),
    .pinIn   (holdRequestN),
    .level   (reqLevel),
    .rise    (reqRise),
    .fall    (reqFall)
  );

  // Acknowledge input matters only in slave role
  lbarb_edge_sync #(
    .INIT (PIN_IDLE_LEVEL)
  ) u_ack_sync (
    .clk_sys (clk_sys),
    .reset   (reset),
    .clkEn   (clkEn),
    .pinIn   (holdAckNIn),
    .level   (),
    .rise    (),
    .fall    (ackFall)
  );

  // ----------------------------------------------------------
  // Timing unit counter
  // ----------------------------------------------------------
  lbarb_unit_timer u_timer (
    .clk_sys (clk_sys),
    .reset   (reset),
    .clkEn   (clkEn),
    .start   (tmrStart),
    .units   (tmrUnits),
    .done    (tmrDone)
  );

  // ----------------------------------------------------------
  // Arbitration sequence
  // ----------------------------------------------------------
  // Drive enables change one state before or after the
  // acknowledge, so the two parties never overlap
  always_comb
  begin
    s_nxt = s_r;
    tmrStart = 1'h0;
    tmrUnits = UNITS_ONE;
    if (clkEn)
    begin
      s_nxt.hreSeen = holdResponseEnable;
      // Hold request edge memory; cleared by the rise
      if (reqFall)
        s_nxt.holdPend = 1'h1;
      else if (reqRise)
        s_nxt.holdPend = 1'h0;

      if (arbitrationMasterSelect != s_r.role)
      begin
        // Role change restarts the sequence of the new role
        s_nxt.role = arbitrationMasterSelect;
        s_nxt.pins.holdAckOe = arbitrationMasterSelect;
        s_nxt.pins.holdAckOut = PIN_IDLE_LEVEL;
        s_nxt.pins.busRequestN = PIN_IDLE_LEVEL;
        s_nxt.pins.addrDataOe = arbitrationMasterSelect;
        s_nxt.pins.strobeOe = arbitrationMasterSelect;
        s_nxt.owned = arbitrationMasterSelect;
        s_nxt.hold = ~arbitrationMasterSelect;
        s_nxt.holdPend = ~reqLevel;
        s_nxt.st = arbitrationMasterSelect ? M_NORMAL : S_HOLD;
      end
      else
      begin
        unique case (s_r.st)
          // Master owns the bus, acknowledge and request high
          M_NORMAL:
          begin
            // Disabled response ignores requests
            if (s_r.holdPend && holdResponseEnable)
            begin
              s_nxt.owned = 1'h0;
              s_nxt.st = M_RELEASE;
            end
          end
          // Let a running cycle finish first
          M_RELEASE:
          begin
            if (!busCycleActive)
            begin
              s_nxt.pins.addrDataOe = 1'h0;
              s_nxt.pins.strobeOe = 1'h0;
              s_nxt.st = M_ACK;
            end
          end
          // Bus already floating; now grant
          M_ACK:
          begin
            s_nxt.pins.holdAckOut = 1'h0;
            s_nxt.hold = 1'h1;
            s_nxt.ackTimeOk = 1'h0;
            tmrStart = 1'h1;
            s_nxt.st = M_HOLD;
          end
          // In hold; may ask for the bus after one unit
          M_HOLD:
          begin
            if (tmrDone)
              s_nxt.ackTimeOk = 1'h1;
            // Request only on real need, not before one unit
            if (extAccessReq && (s_r.ackTimeOk || tmrDone))
              s_nxt.pins.busRequestN = 1'h0;
            if (!s_r.holdPend)
            begin
              // Acknowledge high before touching the bus
              s_nxt.pins.holdAckOut = 1'h1;
              s_nxt.hold = 1'h0;
              tmrStart = 1'h1;
              s_nxt.st = M_EXIT;
            end
          end
          // Back on the bus; request ends one unit later
          M_EXIT:
          begin
            s_nxt.pins.addrDataOe = 1'h1;
            s_nxt.pins.strobeOe = 1'h1;
            s_nxt.owned = 1'h1;
            if (tmrDone)
            begin
              s_nxt.pins.busRequestN = 1'h1;
              s_nxt.st = M_NORMAL;
            end
          end
          // Slave floating, working from internal resources
          S_HOLD:
          begin
            s_nxt.hold = 1'h1;
            if (holdResponseEnable && !s_r.hreSeen)
            begin
              // Enabling gives a short request pulse
              s_nxt.pins.busRequestN = 1'h0;
              tmrUnits = UNITS_TWO;
              tmrStart = 1'h1;
              s_nxt.st = S_PULSE;
            end
            else
            begin
              // Request follows the need for an access
              s_nxt.pins.busRequestN =
                ~(extAccessReq && holdResponseEnable);
              // Grant edge while requesting releases
              if (ackFall && !s_r.pins.busRequestN)
                s_nxt.st = S_TAKE;
            end
          end
          // Initial request pulse of two units
          S_PULSE:
          begin
            if (tmrDone)
            begin
              s_nxt.pins.busRequestN = 1'h1;
              s_nxt.st = S_HOLD;
            end
          end
          // Take the bus over
          S_TAKE:
          begin
            s_nxt.pins.addrDataOe = 1'h1;
            s_nxt.pins.strobeOe = 1'h1;
            s_nxt.owned = 1'h1;
            s_nxt.hold = 1'h0;
            s_nxt.didCycle = 1'h0;
            s_nxt.st = S_OWN;
          end
          // Own the bus; hold request counts only after a cycle
          S_OWN:
          begin
            if (busCycleActive)
              s_nxt.didCycle = 1'h1;
            if (!reqLevel && s_r.didCycle)
            begin
              s_nxt.owned = 1'h0;
              s_nxt.st = S_BACKOFF;
            end
          end
          // Finish the access, then float
          S_BACKOFF:
          begin
            if (!busCycleActive)
            begin
              s_nxt.pins.addrDataOe = 1'h0;
              s_nxt.pins.strobeOe = 1'h0;
              s_nxt.hold = 1'h1;
              s_nxt.st = S_RELEASE;
            end
          end
          // Floating; now release the master
          S_RELEASE:
          begin
            s_nxt.pins.busRequestN = 1'h1;
            s_nxt.st = S_WAIT;
          end
          // Master keeps at least one full cycle
          S_WAIT:
          begin
            if (reqLevel)
              s_nxt.st = S_HOLD;
          end
          default:
          begin
            s_nxt.st = s_r.role ? M_NORMAL : S_HOLD;
          end
        endcase
      end
      // Latch enable only exists on a multiplexed bus
      s_nxt.pins.aleOe = s_nxt.pins.strobeOe & multiplexedMode;
    end
  end

  // ----------------------------------------------------------
  // State register
  // ----------------------------------------------------------
  // Reset lands in slave role, fully floating
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      s_r <= '0;
      s_r.st <= S_HOLD;
      s_r.role <= ROLE_AT_RESET;
      s_r.pins.holdAckOut <= PIN_IDLE_LEVEL;
      s_r.pins.busRequestN <= PIN_IDLE_LEVEL;
      s_r.hold <= 1'h1;
    end
    else
      s_r <= s_nxt;
  end

  // ----------------------------------------------------------
  // Outputs, straight from the state register
  // ----------------------------------------------------------
  assign pinOut = s_r.pins;
  assign busOwned = s_r.owned;
  assign holdStatus = s_r.hold;

endmodule
`default_nettype wire

// ### test/lbarb_arbiter_chk.sv
// Port checker for the local bus hold arbiter
`timescale 1ns/100ps
`default_nettype none
module lbarb_arbiter_chk
  import lbarb_pkg::*;
(
  input wire logic           clk_sys,
  input wire logic           reset,
  input wire logic           clkEn,
  input wire logic           arbitrationMasterSelect,
  input wire logic           holdResponseEnable,
  input wire logic           multiplexedMode,
  input wire logic           holdRequestN,
  input wire logic           holdAckNIn,
  input wire logic           extAccessReq,
  input wire logic           busCycleActive,
  input wire lbarb_pin_out_t pinOut,
  input wire logic           busOwned,
  input wire logic           holdStatus
);
  // ----------------------------------------------------------
  // Helper: a bus cycle seen during the present ownership
  // ----------------------------------------------------------
  logic seenCyc_r;  // Cleared whenever the bus is not owned
  always_ff @(posedge clk_sys or posedge reset)
    if (reset)
      seenCyc_r <= 1'h0;
    else
      seenCyc_r <= busOwned & (seenCyc_r | busCycleActive);

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  // ----------------------------------------------------------
  // Properties
  // ----------------------------------------------------------
  property p_ale;
    pinOut.aleOe |-> pinOut.strobeOe && $past(multiplexedMode);
  endproperty
  a_ale: assert property (p_ale) else $error("ale drive");
  property p_tri;
    holdStatus |-> !pinOut.addrDataOe && !pinOut.strobeOe;
  endproperty
  a_tri: assert property (p_tri) else $error("hold drive");
  property p_ackRel;
    $fell(pinOut.holdAckOut) |-> !$past(pinOut.addrDataOe);
  endproperty
  a_ackRel: assert property (p_ackRel) else $error("ack early");
  property p_ackFirst;
    $rose(pinOut.addrDataOe) && arbitrationMasterSelect
      |-> $past(pinOut.holdAckOut);
  endproperty
  a_ackFirst: assert property (p_ackFirst) else $error("drive early");
  property p_reqEarly;
    $fell(pinOut.busRequestN) && arbitrationMasterSelect
      |-> !$past(pinOut.holdAckOut, 2) && $past(extAccessReq);
  endproperty
  a_reqEarly: assert property (p_reqEarly)
    else $error("req early");
  property p_reqExit;
    $rose(pinOut.holdAckOut)
      |-> ##1 $stable(pinOut.busRequestN) ##1 pinOut.busRequestN;
  endproperty
  a_reqExit: assert property (p_reqExit) else $error("req exit");
  sequence s_holdAsk;
    arbitrationMasterSelect && holdResponseEnable && !holdRequestN
      && !busCycleActive;
  endsequence
  property p_enter;
    s_holdAsk [*8] |-> !pinOut.holdAckOut && holdStatus;
  endproperty
  a_enter: assert property (p_enter) else $error("no hold");
  property p_exit;
    (arbitrationMasterSelect && holdRequestN) [*6] |-> pinOut.holdAckOut;
  endproperty
  a_exit: assert property (p_exit) else $error("no exit");
  property p_slvRel;
    $rose(pinOut.busRequestN) && !arbitrationMasterSelect
      |-> holdStatus && !pinOut.addrDataOe && !busOwned;
  endproperty
  a_slvRel: assert property (p_slvRel) else $error("slave rel");
  property p_slvTake;
    $rose(busOwned) && !arbitrationMasterSelect |-> !$past(holdAckNIn, 3);
  endproperty
  a_slvTake: assert property (p_slvTake) else $error("slave take");
  property p_slvKeep;
    $fell(busOwned) && !$past(arbitrationMasterSelect, 2) |-> seenCyc_r;
  endproperty
  a_slvKeep: assert property (p_slvKeep) else $error("no cycle");
  property p_slvWait;
    $fell(pinOut.busRequestN) && !arbitrationMasterSelect
      |-> $past(holdRequestN, 2);
  endproperty
  a_slvWait: assert property (p_slvWait) else $error("req again");
  c_hold: cover property ($fell(pinOut.holdAckOut));
  c_take: cover property ($rose(busOwned) && !arbitrationMasterSelect);
  c_en: cover property ($rose(holdResponseEnable));
endmodule

bind lbarb_arbiter lbarb_arbiter_chk u_chk (
  .clk_sys(clk_sys), .reset(reset), .clkEn(clkEn),
  .arbitrationMasterSelect(arbitrationMasterSelect),
  .holdResponseEnable(holdResponseEnable),
  .multiplexedMode(multiplexedMode), .holdRequestN(holdRequestN),
  .holdAckNIn(holdAckNIn), .extAccessReq(extAccessReq),
  .busCycleActive(busCycleActive), .pinOut(pinOut),
  .busOwned(busOwned), .holdStatus(holdStatus));
`default_nettype wire

// ### test/lbarb_peer.sv
// Behavioural far-side controller in arbitration master role
`timescale 1ns/100ps
`default_nettype none
module lbarb_peer
  import lbarb_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       reset,
  input  wire logic       slaveReqN,  // Slave bus request
  input  wire logic       needBus,    // Own access wanted
  input  wire logic [2:0] slowAns,    // Extra answer delay
  output logic            holdAckN,   // Acknowledge to slave
  output logic            peerReqN    // Own bus request
);
  logic [1:0] st;   // 0 normal, 1 hold, 2 exit
  logic [4:0] cnt;  // Cycles in the present step
  logic [4:0] lim;  // Sync plus cycle completion time
  assign lim = 5'h2 + {2'h0, slowAns};
  // ----------------------------------------------------------
  // Hold handshake; slow answers stress the slave's waits
  // ----------------------------------------------------------
  always_ff @(posedge clk_sys or posedge reset)
    if (reset)
    begin
      st <= 2'h0;
      cnt <= 5'h0;
      holdAckN <= 1'h1;
      peerReqN <= 1'h1;
    end
    else
      case (st)
        2'h0:
        begin
          cnt <= slaveReqN ? 5'h0 : cnt + 5'h1;
          if (!slaveReqN && cnt >= lim)
          begin
            holdAckN <= 1'h0;  // Bus already off
            st <= 2'h1;
            cnt <= 5'h0;
          end
        end
        2'h1:
        begin
          if (cnt != 5'h1f)
            cnt <= cnt + 5'h1;
          if (needBus && cnt >= 5'h1)
            peerReqN <= 1'h0;
          if (slaveReqN)
          begin
            st <= 2'h2;
            cnt <= 5'h0;
          end
        end
        default:
        begin
          cnt <= cnt + 5'h1;
          if (cnt == lim)
            holdAckN <= 1'h1;
          if (cnt == lim + 5'(UNIT_CYCLES))
          begin
            peerReqN <= 1'h1;
            st <= 2'h0;
            cnt <= 5'h0;
          end
        end
      endcase
endmodule
`default_nettype wire

// ### test/lbarb_arbiter_tb.sv
// Self-checking bench of the hold arbiter in both roles
`timescale 1ns/100ps
`default_nettype none
module lbarb_arbiter_tb;
  import lbarb_pkg::*;
  logic clk_sys, reset, roleSel, holdEn, muxMode, extReq, cycAct, clkEn;
  logic tbHoldN, slvPh, needBus, holdReqN, ackIn, owned, inHold;
  logic peerAckN, peerReqN;
  logic [2:0] slowAns;  // Partner answer delay
  lbarb_pin_out_t pins;
  int errors, num_checks, rs, i, k, n;
  // ----------------------------------------------------------
  // Wiring: bench drives hold request as master, partner as slave
  // ----------------------------------------------------------
  assign holdReqN = slvPh ? peerReqN : tbHoldN;
  // Pull-up on the acknowledge wire when nobody drives it
  assign ackIn = slvPh ? peerAckN
               : (pins.holdAckOe ? pins.holdAckOut : 1'h1);
  lbarb_arbiter DUT (.clk_sys(clk_sys), .reset(reset), .clkEn(clkEn),
    .arbitrationMasterSelect(roleSel), .holdResponseEnable(holdEn),
    .multiplexedMode(muxMode), .holdRequestN(holdReqN),
    .holdAckNIn(ackIn), .extAccessReq(extReq),
    .busCycleActive(cycAct), .pinOut(pins), .busOwned(owned),
    .holdStatus(inHold));
  lbarb_peer u_peer (.clk_sys(clk_sys), .reset(reset),
    .slaveReqN(pins.busRequestN), .needBus(needBus),
    .slowAns(slowAns), .holdAckN(peerAckN), .peerReqN(peerReqN));
  initial
  begin
    clk_sys = 1'h0;
    forever #5 clk_sys = ~clk_sys;
  end
  // ----------------------------------------------------------
  // Expectations and helpers
  // ----------------------------------------------------------
  // Pins of an idle owner (master) or a parked slave
  function automatic lbarb_pin_out_t idlePins(input logic m, input logic x);
    idlePins = '{holdAckOut:1'h1, holdAckOe:m, busRequestN:1'h1,
      addrDataOe:m, strobeOe:m, aleOe:m & x};
  endfunction
  function automatic logic done(input int s);
    case (s)
      0: done = !pins.holdAckOut;
      1: done = pins.holdAckOut;
      2: done = owned;
      3: done = pins.busRequestN;
      default: done = holdReqN;
    endcase
  endfunction
  task automatic wrap_up();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic ok, input string m);
    num_checks++;
    if (ok !== 1'h1)
    begin
      errors++;
      $display("MISMATCH t=%0t %s", $time, m);
    end
  endtask
  task automatic cyc(input int c);
    repeat (c) @(negedge clk_sys);
  endtask
  // Bounded wait; running out ends the run
  task automatic waitOn(input int s);
    for (int w = 0; w < 80; w++)
    begin
      @(negedge clk_sys);
      if (done(s) === 1'h1)
        return;
    end
    errors++;
    $display("MISMATCH t=%0t stuck %0d", $time, s);
    wrap_up();
  endtask
  // ----------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------
  initial
  begin
    errors = 0;
    num_checks = 0;
    rs = $urandom(41);
    {reset, roleSel, holdEn, muxMode, extReq, cycAct} = 6'h20;
    {clkEn, tbHoldN, slvPh, needBus, slowAns} = 7'h60;
    cyc(2);
    reset = 1'h0;
    cyc(1);
    chk(pins === idlePins(0, 0) && inHold === 1'h1, "reset");
    roleSel = 1'h1;
    for (i = 0; i < 2; i++)
    begin
      muxMode = i[0];
      cyc(2);
      chk(pins === idlePins(1, muxMode), "master idle");
    end
    holdEn = 1'h1;
    // Master hold entry and exit, random cycle in progress
    for (i = 0; i < 6; i++)
    begin
      k = $urandom_range(6);
      extReq = 1'($urandom_range(1));
      cycAct = (k != 0);
      tbHoldN = 1'h0;
      for (n = 0; n < k; n++)
      begin
        @(negedge clk_sys);
        chk(pins.holdAckOut === 1'h1, "ack in cycle");
      end
      cycAct = 1'h0;
      waitOn(0);
      chk(!pins.addrDataOe && !pins.strobeOe && inHold, "enter");
      cyc(4);
      chk(pins.busRequestN === !extReq, "req in hold");
      tbHoldN = 1'h1;
      waitOn(1);
      chk(pins.addrDataOe === 1'h0, "ack first");
      cyc(1);
      chk(pins.addrDataOe === 1'h1 && owned === 1'h1, "back");
      cyc(1);
      chk(pins.busRequestN === 1'h1, "req high");
      extReq = 1'h0;
    end
    // Hold response switched off, then on again
    holdEn = 1'h0;
    tbHoldN = 1'h0;
    cyc(12);
    chk(pins.holdAckOut === 1'h1 && owned === 1'h1, "ignored");
    holdEn = 1'h1;
    waitOn(0);
    tbHoldN = 1'h1;
    waitOn(1);
    cyc(3);
    // Slave role against the partner master
    roleSel = 1'h0;
    holdEn = 1'h0;
    slvPh = 1'h1;
    cyc(4);
    chk(pins === idlePins(0, muxMode) && inHold, "slave idle");
    // Enable raised while frozen: no pulse may start yet
    clkEn = 1'h0;
    holdEn = 1'h1;
    cyc(3);
    chk(pins === idlePins(0, muxMode), "frozen");
    clkEn = 1'h1;
    n = 0;
    repeat (12)
    begin
      @(negedge clk_sys);
      n += (pins.busRequestN === 1'h0);
    end
    chk(n == 2 * UNIT_CYCLES, "enable pulse");
    cyc(10);
    for (i = 0; i < 4; i++)
    begin
      slowAns = 3'($urandom_range(7));
      extReq = 1'h1;
      waitOn(2);
      chk(!pins.busRequestN && !ackIn && pins.addrDataOe, "take");
      needBus = 1'h1;
      cyc(8);
      chk(owned === 1'h1, "first cycle");
      cycAct = 1'h1;
      cyc(1 + $urandom_range(3));
      chk(pins.addrDataOe === 1'h1, "finish access");
      cycAct = 1'h0;
      waitOn(3);
      chk(!pins.addrDataOe && inHold, "tristate first");
      needBus = 1'h0;
      for (n = 0; n < 40 && holdReqN === 1'h0; n++)
      begin
        chk(pins.busRequestN === 1'h1, "early req");
        @(negedge clk_sys);
      end
      // Partner never gave up its request: end the run
      if (n >= 40)
      begin
        errors++;
        $display("MISMATCH t=%0t partner request stuck", $time);
        wrap_up();
      end
    end
    extReq = 1'h0;
    cyc(10);
    wrap_up();
  end
endmodule
`default_nettype wire
